// *** hw/rmd_ctrl.sv ***
/* rmd_ctrl: regenerating word memory with action cycles and a drum block-transfer sequencer.
 * assumes the arithmetic unit holds its request until au_done and stays off the memory while drum_busy is high.
 */
`timescale 1ns/1ps
module rmd_ctrl #(
    parameter int REV_CYCLES = rmd_pkg::REV_CYCLES_DOC
) (
    input wire logic clk,
    input wire logic rst_b,
    input rmd_pkg::rmd_req_s au_req,
    input wire rmd_pkg::rmd_addr_t pc_addr,
    input wire rmd_pkg::rmd_addr_t order_addr,
    input wire rmd_pkg::rmd_word_t acc_word,
    input wire rmd_pkg::rmd_word_t opreg_word,
    output logic au_done,
    output rmd_pkg::rmd_word_t rd_word,
    output rmd_pkg::rmd_gate_s gate,
    input wire logic drum_req,
    input wire rmd_pkg::rmd_word_t drum_order,
    output logic drum_busy,
    output logic drum_done,
    output logic drum_bad,
    output logic pc_set,
    output rmd_pkg::rmd_field_t pc_set_addr
);
    import rmd_pkg::*;

    // ----------------------------------------------------------------
    // derived timing and helpers
    // ----------------------------------------------------------------
    // bits are spread evenly over the transfer revolutions
    localparam int BIT_CYCLES = REV_CYCLES * XFER_REVS / (TRACK_WORDS * WORD_W);
    localparam logic [BITCNT_W-1:0] LAST_BIT = BITCNT_W'(WORD_W - 1);
    localparam logic [BITCNT_W-1:0] LAST_WORD = BITCNT_W'(TRACK_WORDS - 1);
    // pull a 12-bit order field
    function automatic rmd_field_t field_at(input rmd_word_t w, input int lsb);
        field_at = w[lsb +: FIELD_W];
    endfunction

    // word slot on the drum
    function automatic logic [DRUM_IDX_W-1:0] drum_idx(input logic [TRACK_W-1:0] t,
                                                       input logic [BITCNT_W-1:0] w);
        drum_idx = DRUM_IDX_W'(t) * DRUM_IDX_W'(TRACK_WORDS) + DRUM_IDX_W'(w);
    endfunction

    // ----------------------------------------------------------------
    // state and datapath signals
    // ----------------------------------------------------------------
    rmd_ctrl_s s_q;
    rmd_ctrl_s s_d;
    rmd_word_t drum_mem [DRUM_WORDS];   // serial store, one word per slot
    rmd_word_t plane_ff;                // bit ff of every plane
    rmd_addr_t arr_addr;                // address to all planes
    rmd_word_t merged;                  // composite write word
    // action cycle, plane strobes, drum strobes and order decode
    logic in_act, p_sense, p_load, p_store, rev_hit, tick_hit, drum_act, drum_bit, adv, op_ok, track_ok;
    logic [DRUM_IDX_W-1:0] slot;

    // ----------------------------------------------------------------
    // address multiplexer, plane strobes, bit-planes and drum decode
    // ----------------------------------------------------------------
    assign in_act = (s_q.mst == M_ACT_SENSE) || (s_q.mst == M_ACT_WRITE);
    assign arr_addr = in_act ? s_q.addr : s_q.regen;
    assign p_sense = (s_q.mst == M_REGEN_SENSE) || ((s_q.mst == M_ACT_SENSE) && !s_q.act_wr);
    assign p_load = (s_q.mst == M_ACT_SENSE) && s_q.act_wr;
    assign p_store = (s_q.mst == M_REGEN_WRITE) || (s_q.mst == M_ACT_WRITE);

    // accumulator address field, rest from operand
    assign merged = (acc_word & ADDR_FIELD_MASK) | (opreg_word & ~ADDR_FIELD_MASK);

    for (genvar p = 0; p < PLANES; p++) begin : g_plane
        rmd_plane #(.AW(ADDR_W), .NSPOT(DEPTH)) u_plane (
            .clk(clk),
            .rst_b(rst_b),
            .addr(arr_addr),
            .sense(p_sense),
            .load(p_load),
            .load_bit(s_q.wdata[p]),
            .store(p_store),
            .ff(plane_ff[p])
        );
    end

    // drum decode and timing strobes
    assign rev_hit = s_q.rev_cnt == CNT_W'(REV_CYCLES - 1);
    assign tick_hit = s_q.tick == CNT_W'(BIT_CYCLES - 1);
    assign drum_act = (s_q.dst_st == D_FETCH) || (s_q.dst_st == D_STORE);
    // whole word carries the drum order
    assign op_ok = (drum_order[OP_LSB +: OP_W] == OP_MEM_TO_DRUM)
                || (drum_order[OP_LSB +: OP_W] == OP_DRUM_TO_MEM);
    assign track_ok = drum_order[TRACK_LSB +: TRACK_W] < TRACK_W'(TRACKS);
    assign slot = drum_idx(s_q.track, s_q.word_cnt);
    assign drum_bit = drum_mem[slot][WORD_W - 1 - int'(s_q.bit_cnt)];

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        adv = 1'b0;
        // pulses default low
        s_d.done = 1'b0;
        s_d.fin = 1'b0;
        s_d.gate = '0;
        s_d.ddone = 1'b0;
        s_d.dbad = 1'b0;
        s_d.pc_set = 1'b0;
        // free-running drum angle; bit timer, restarted at sync and after each drum fetch
        s_d.rev_cnt = rev_hit ? '0 : s_q.rev_cnt + 1'b1;
        s_d.tick = tick_hit ? '0 : s_q.tick + 1'b1;

        // memory cycle sequencer
        case (s_q.mst)
            M_REGEN_SENSE: s_d.mst = M_REGEN_WRITE;
            M_REGEN_WRITE: begin
                s_d.regen = s_q.regen + 1'b1;
                // interlock: decide only at cycle end
                if (drum_act) begin
                    // drum words take priority over the arithmetic unit
                    s_d.mst = M_ACT_SENSE;
                    s_d.act_drum = 1'b1;
                    s_d.act_wr = !s_q.to_drum;
                    s_d.addr = s_q.mem_ptr;
                    s_d.wdata = s_q.qm;
                    s_d.kind = RMD_READ;
                    s_d.dest = RMD_TO_QM;
                    s_d.clr = 1'b0;
                end else if (au_req.valid) begin
                    s_d.mst = M_ACT_SENSE;
                    s_d.act_drum = 1'b0;
                    s_d.act_wr = au_req.kind == RMD_WRITE;
                    s_d.addr = (au_req.kind == RMD_FETCH) ? pc_addr : order_addr;
                    s_d.kind = au_req.kind;
                    s_d.dest = au_req.dst;
                    s_d.clr = au_req.clear_acc;
                    case (au_req.src)
                        RMD_FROM_ACC: s_d.wdata = acc_word;
                        RMD_FROM_COMPOSITE: s_d.wdata = merged;
                        default: s_d.wdata = opreg_word;
                    endcase
                end else begin
                    s_d.mst = M_REGEN_SENSE;
                end
            end
            M_ACT_SENSE: s_d.mst = M_ACT_WRITE;
            M_ACT_WRITE: begin
                s_d.mst = M_REGEN_SENSE;
                s_d.fin = s_q.act_drum;
                s_d.done = !s_q.act_drum;
                if (!s_q.act_wr) begin
                    s_d.rd_word = plane_ff;
                end
                if (!s_q.act_drum && !s_q.act_wr) begin
                    if (s_q.kind == RMD_FETCH || s_q.dest == RMD_TO_ORDER) begin
                        s_d.gate.to_order = 1'b1;
                    end else begin
                        s_d.gate.to_opreg = 1'b1;
                        // on to the accumulator via the adder
                        s_d.gate.opreg_to_acc = s_q.dest == RMD_TO_ACC;
                        s_d.gate.clear_acc = (s_q.dest == RMD_TO_ACC) && s_q.clr;
                        s_d.gate.opreg_to_qm = s_q.dest == RMD_TO_QM;
                    end
                end
            end
            default: s_d.mst = M_REGEN_SENSE;
        endcase

        // drum block sequencer
        case (s_q.dst_st)
            D_IDLE: begin
                if (drum_req) begin
                    if (!op_ok || !track_ok) begin
                        s_d.ddone = 1'b1;
                        s_d.dbad = 1'b1;
                    end else begin
                        s_d.dst_st = D_SYNC;
                        s_d.to_drum = drum_order[OP_LSB +: OP_W] == OP_MEM_TO_DRUM;
                        s_d.mem_ptr = ADDR_W'(field_at(drum_order, MADDR_LSB));
                        s_d.track = drum_order[TRACK_LSB +: TRACK_W];
                        s_d.jump = field_at(drum_order, JUMP_LSB);
                        s_d.word_cnt = '0;
                        s_d.bit_cnt = '0;
                    end
                end
            end
            D_SYNC: begin
                // wait for the index, then four revolutions
                if (rev_hit) begin
                    s_d.tick = '0;
                    s_d.dst_st = s_q.to_drum ? D_FETCH : D_SHIFT;
                end
            end
            D_FETCH: begin
                if (s_q.fin) begin
                    s_d.qm = s_q.rd_word;
                    s_d.tick = '0;
                    s_d.dst_st = D_SHIFT;
                end
            end
            D_SHIFT: begin
                if (tick_hit) begin
                    s_d.qm = {s_q.qm[WORD_W-2:0], drum_bit};
                    s_d.bit_cnt = s_q.bit_cnt + 1'b1;
                    if (s_q.bit_cnt == LAST_BIT) begin
                        s_d.bit_cnt = '0;
                        adv = s_q.to_drum;
                        if (!s_q.to_drum) begin
                            s_d.dst_st = D_STORE;
                        end
                    end
                end
            end
            D_STORE: adv = s_q.fin;
            D_END: begin
                s_d.ddone = 1'b1;
                s_d.pc_set = 1'b1;
                s_d.pc_out = s_q.jump;
                s_d.dst_st = D_IDLE;
            end
            default: s_d.dst_st = D_IDLE;
        endcase

        // whole track: step to the next word or finish
        if (adv) begin
            s_d.word_cnt = s_q.word_cnt + 1'b1;
            s_d.mem_ptr = s_q.mem_ptr + 1'b1;
            s_d.pc_set = 1'b1;
            s_d.pc_out = FIELD_W'(s_d.mem_ptr);
            if (s_q.word_cnt == LAST_WORD) begin
                s_d.dst_st = D_END;
            end else begin
                s_d.dst_st = s_q.to_drum ? D_FETCH : D_SHIFT;
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // drum surface written one bit per tick, no reset on storage
    always_ff @(posedge clk) begin
        if (s_q.dst_st == D_SHIFT && tick_hit && s_q.to_drum) begin
            drum_mem[slot][WORD_W - 1 - int'(s_q.bit_cnt)] <= s_q.qm[WORD_W-1];
        end
    end

    // ----------------------------------------------------------------
    // outputs and checks
    // ----------------------------------------------------------------
    assign au_done = s_q.done;
    assign rd_word = s_q.rd_word;
    assign gate = s_q.gate;
    assign drum_busy = s_q.dst_st != D_IDLE;
    assign drum_done = s_q.ddone;
    assign drum_bad = s_q.dbad;
    assign pc_set = s_q.pc_set;
    assign pc_set_addr = s_q.pc_out;

    // checks, all in the one clock domain
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_regen_addr: assert property (
        s_q.mst == M_REGEN_SENSE |=> arr_addr == $past(arr_addr)) else $error("rewrite not at sensed spot");
    a_regen_step: assert property (
        s_q.mst == M_REGEN_WRITE |=> s_q.regen == $past(s_q.regen) + 1'b1) else $error("regen counter stuck");
    a_act_next: assert property (
        s_q.mst == M_REGEN_WRITE && au_req.valid |=> s_q.mst == M_ACT_SENSE ##1 s_q.mst == M_ACT_WRITE)
        else $error("action did not follow regeneration");
    a_resume_regen: assert property (
        s_q.mst == M_ACT_WRITE |=> s_q.mst == M_REGEN_SENSE ##1 s_q.mst == M_REGEN_WRITE)
        else $error("regeneration not resumed");
    a_fetch_pc: assert property (
        s_q.mst == M_REGEN_WRITE && !drum_act && au_req.valid && au_req.kind == RMD_FETCH
        |=> arr_addr == $past(pc_addr)) else $error("fetch not addressed by program counter");
    a_done_single: assert property (
        au_done |=> !au_done ##1 !au_done ##1 !au_done) else $error("completion repeated");
    a_comp_field: assert property (
        s_q.mst == M_REGEN_WRITE && !drum_act && au_req.valid && au_req.kind == RMD_WRITE
        && au_req.src == RMD_FROM_COMPOSITE |=> (s_q.wdata & ADDR_FIELD_MASK) == ($past(acc_word) & ADDR_FIELD_MASK))
        else $error("composite address field wrong");
    a_bad_track: assert property (
        s_q.dst_st == D_IDLE && drum_req && !track_ok |=> drum_done && drum_bad && !drum_busy)
        else $error("invalid track not refused");
    a_pc_reload: assert property (
        drum_done && !drum_bad |-> pc_set && pc_set_addr == s_q.jump) else $error("program counter not reloaded");

endmodule

// *** hw/rmd_pkg.sv ***
/*
 * rmd_pkg: constants, enumerations and carrier structs shared by the
 * regenerative memory controller and its bit-plane units.
 * assumes a 125 MHz single clock and a 40-stage arithmetic unit outside.
 */
package rmd_pkg;

    // ----------------------------------------------------------------
    // word and array geometry
    // ----------------------------------------------------------------
    localparam int WORD_W = 40;       // one plane per arithmetic stage
    localparam int PLANES = 40;
    localparam int ADDR_W = 10;       // 32 x 32 spots per plane
    localparam int ARRAY_SIDE = 32;
    localparam int DEPTH = ARRAY_SIDE * ARRAY_SIDE;

    // ----------------------------------------------------------------
    // full-word drum order layout (stage 0 is the leftmost, bit 39)
    // ----------------------------------------------------------------
    localparam int OP_LSB = 32;       // stages 0-7
    localparam int OP_W = 8;
    localparam int FIELD_W = 12;
    localparam int MADDR_LSB = 20;    // stages 8-19
    localparam int TRACK_LSB = 12;    // stages 20-27
    localparam int TRACK_W = 8;
    localparam int JUMP_LSB = 0;      // stages 28-39
    localparam logic [OP_W-1:0] OP_MEM_TO_DRUM = 8'hBD;
    localparam logic [OP_W-1:0] OP_DRUM_TO_MEM = 8'hBC;
    // address field of an order, used for composite writes
    localparam logic [WORD_W-1:0] ADDR_FIELD_MASK = 40'h00FFF00000;

    // ----------------------------------------------------------------
    // drum store and timing
    // ----------------------------------------------------------------
    localparam int TRACKS = 200;
    localparam int TRACK_WORDS = 50;
    localparam int DRUM_WORDS = TRACKS * TRACK_WORDS;
    localparam int DRUM_IDX_W = 14;
    localparam int DRUM_REV_US = 17000;   // one revolution
    localparam int CLK_PERIOD_NS = 8;
    localparam int REV_CYCLES_DOC = DRUM_REV_US * 1000 / CLK_PERIOD_NS;
    localparam int XFER_REVS = 4;         // plus up to one rev of sync
    localparam int CNT_W = 24;
    localparam int BITCNT_W = 6;

    typedef logic [WORD_W-1:0] rmd_word_t;
    typedef logic [ADDR_W-1:0] rmd_addr_t;
    typedef logic [FIELD_W-1:0] rmd_field_t;

    typedef enum logic [1:0] {RMD_FETCH, RMD_READ, RMD_WRITE} rmd_act_e;
    typedef enum logic [1:0] {RMD_TO_OPREG, RMD_TO_ORDER, RMD_TO_ACC, RMD_TO_QM} rmd_dst_e;
    typedef enum logic [1:0] {RMD_FROM_ACC, RMD_FROM_OPREG, RMD_FROM_COMPOSITE} rmd_src_e;
    typedef enum logic [1:0] {M_REGEN_SENSE, M_REGEN_WRITE, M_ACT_SENSE, M_ACT_WRITE} rmd_mem_e;
    typedef enum logic [2:0] {D_IDLE, D_SYNC, D_FETCH, D_SHIFT, D_STORE, D_END} rmd_drum_e;

    // action request from the arithmetic unit
    typedef struct packed {
        logic valid;
        rmd_act_e kind;
        rmd_dst_e dst;
        rmd_src_e src;
        logic clear_acc;
    } rmd_req_s;

    // register gating strobes toward the arithmetic unit
    typedef struct packed {
        logic to_opreg;
        logic to_order;
        logic opreg_to_acc;    // operand reg -> adder -> adder out -> acc
        logic clear_acc;
        logic opreg_to_qm;
    } rmd_gate_s;

    // whole state of the controller
    typedef struct packed {
        rmd_mem_e mst;
        rmd_drum_e dst_st;
        rmd_addr_t regen;
        rmd_addr_t addr;
        logic act_drum;
        logic act_wr;
        rmd_act_e kind;
        rmd_dst_e dest;
        logic clr;
        rmd_word_t wdata;
        rmd_word_t rd_word;
        logic done;
        logic fin;
        rmd_gate_s gate;
        logic to_drum;
        rmd_addr_t mem_ptr;
        logic [TRACK_W-1:0] track;
        rmd_field_t jump;
        logic [BITCNT_W-1:0] word_cnt;
        logic [BITCNT_W-1:0] bit_cnt;
        logic [CNT_W-1:0] rev_cnt;
        logic [CNT_W-1:0] tick;
        rmd_word_t qm;
        logic ddone;
        logic dbad;
        logic pc_set;
        rmd_field_t pc_out;
    } rmd_ctrl_s;

    typedef struct packed {
        logic ff;
    } rmd_plane_s;

endpackage

// *** hw/rmd_plane.sv ***
/*
 * rmd_plane: one storage bit-plane with its sense/write flip-flop.
 * assumes the controller sequences sense or load, then store, and never
 * asks for two of them in one cycle.
 */
`timescale 1ns/1ps
module rmd_plane #(
    parameter int AW = rmd_pkg::ADDR_W,
    parameter int NSPOT = rmd_pkg::DEPTH
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [AW-1:0] addr,
    input wire logic sense,      // read addressed spot into ff
    input wire logic load,       // load ff from write data
    input wire logic load_bit,
    input wire logic store,      // rewrite spot from ff, then clear ff
    output logic ff
);
    import rmd_pkg::*;

    // ----------------------------------------------------------------
    // storage and state
    // ----------------------------------------------------------------
    logic spot [NSPOT];          // no reset: contents survive only by rewrite
    rmd_plane_s s_q;
    rmd_plane_s s_d;

    assign ff = s_q.ff;

    // sensing only ever sets ff, so a sensed 0 leaves it untouched
    always_comb begin
        s_d = s_q;
        if (sense) begin
            s_d.ff = s_q.ff | spot[addr];
        end else if (load) begin
            s_d.ff = load_bit;
        end else if (store) begin
            s_d.ff = 1'b0;
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // the ff decides what goes back, so no erase step is needed
    always_ff @(posedge clk) begin
        if (store) begin
            spot[addr] <= s_q.ff;
        end
    end

    a_ff_cleared: assert property (@(posedge clk) disable iff (!rst_b)
        store && !sense && !load |=> !ff) else $error("bit ff not cleared after store");

endmodule

// *** test/rmd_au_model.sv ***
/* rmd_au_model: arithmetic unit side of the action port.
   assumes the bench calls act() and that clk runs freely. */
`timescale 1ns/1ps
module rmd_au_model
    import rmd_pkg::*;
(
    input wire logic clk,
    input wire logic au_done,
    output rmd_pkg::rmd_req_s au_req,
    output rmd_pkg::rmd_addr_t pc_addr,
    output rmd_pkg::rmd_addr_t order_addr,
    output rmd_pkg::rmd_word_t acc_word,
    output rmd_pkg::rmd_word_t opreg_word
);
    // idle request at time zero
    initial begin
        au_req = '0;
        pc_addr = '0;
        order_addr = '0;
        acc_word = '0;
        opreg_word = '0;
    end
    // one action; the unused address source gets the inverse so a wrong mux shows
    task automatic act(input rmd_act_e k, input rmd_dst_e d, input rmd_src_e s, input logic c,
                       input rmd_addr_t a, input rmd_word_t acc, input rmd_word_t op);
        int n;
        @(negedge clk);
        pc_addr = (k == RMD_FETCH) ? a : ~a;
        order_addr = (k == RMD_FETCH) ? ~a : a;
        acc_word = acc;
        opreg_word = op;
        au_req = '{1'b1, k, d, s, c};
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (au_done !== 1'b1 && n < 20);
        au_req.valid = 1'b0;
    endtask
endmodule

// *** test/rmd_ctrl_tb_top.sv ***
/* rmd_ctrl_tb_top: self-checking bench for the memory controller.
   assumes a short drum revolution (REV_CYCLES 2000) to keep runs brief. */
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; $display("BAD %0t mismatch", $time); end end
module rmd_ctrl_tb_top;
    import rmd_pkg::*;
    logic clk, rst_b, drum_req, au_done, drum_busy, drum_done, drum_bad, pc_set;
    rmd_req_s au_req;
    rmd_addr_t pc_addr, order_addr;
    rmd_word_t acc_word, opreg_word, rd_word, drum_order;
    rmd_gate_s gate;
    rmd_field_t pc_set_addr;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    localparam int REV = 2000;
    rmd_ctrl #(.REV_CYCLES(REV)) u_dut (.clk, .rst_b, .au_req, .pc_addr, .order_addr, .acc_word,
        .opreg_word, .au_done, .rd_word, .gate, .drum_req, .drum_order, .drum_busy, .drum_done,
        .drum_bad, .pc_set, .pc_set_addr);
    rmd_au_model u_au (.clk, .au_done, .au_req, .pc_addr, .order_addr, .acc_word, .opreg_word);
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    task automatic give_verdict;
        if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // hang guard, well above two track transfers
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            give_verdict();
        end
    end
    task automatic wr(input rmd_addr_t a, input rmd_src_e s, input rmd_word_t acc, input rmd_word_t op);
        u_au.act(RMD_WRITE, RMD_TO_OPREG, s, 1'b0, a, acc, op);
        `CHK(au_done, 1'b1)
    endtask
    task automatic rd(input rmd_act_e k, input rmd_dst_e d, input rmd_addr_t a, input rmd_word_t x);
        u_au.act(k, d, RMD_FROM_OPREG, 1'b1, a, '0, '0);
        `CHK(au_done, 1'b1)
        `CHK(rd_word, x)
    endtask
    task automatic t_rw;
        wr(10'h005, RMD_FROM_ACC, 40'hF0F0F0F0F0, 40'h0);
        `CHK(gate, '0)
        wr(10'h3FF, RMD_FROM_OPREG, 40'h0, 40'h0123456789);
        rd(RMD_READ, RMD_TO_OPREG, 10'h005, 40'hF0F0F0F0F0);
        `CHK(gate.to_opreg, 1'b1)
        rd(RMD_READ, RMD_TO_OPREG, 10'h3FF, 40'h0123456789);
        rd(RMD_READ, RMD_TO_OPREG, 10'h3FF, 40'h0123456789);
    endtask
    task automatic t_comp;
        wr(10'h007, RMD_FROM_COMPOSITE, 40'h1234567890, 40'hAAAAAAAAAA);
        rd(RMD_READ, RMD_TO_OPREG, 10'h007, (40'h1234567890 & ADDR_FIELD_MASK) | (40'hAAAAAAAAAA & ~ADDR_FIELD_MASK));
    endtask
    task automatic t_gates;
        rd(RMD_READ, RMD_TO_ACC, 10'h005, 40'hF0F0F0F0F0);
        `CHK({gate.opreg_to_acc, gate.clear_acc}, 2'b11)
        rd(RMD_READ, RMD_TO_QM, 10'h005, 40'hF0F0F0F0F0);
        `CHK(gate.opreg_to_qm, 1'b1)
        rd(RMD_FETCH, RMD_TO_OPREG, 10'h005, 40'hF0F0F0F0F0);
        `CHK(gate.to_order, 1'b1)
    endtask
    task automatic drum(input logic [7:0] op, input rmd_field_t ma, input logic [7:0] tr, input rmd_field_t jp,
                        input logic bad);
        int n;
        int sets;
        @(negedge clk);
        drum_order = {op, ma, tr, jp};
        drum_req = 1'b1;
        @(negedge clk);
        drum_req = 1'b0;
        `CHK(drum_busy, !bad)
        n = 0;
        sets = 0;
        // a refused order answers in this very cycle, so look before waiting
        while (drum_done !== 1'b1 && n < 25000) begin
            if (pc_set === 1'b1) sets++;
            @(negedge clk);
            n++;
        end
        if (pc_set === 1'b1) sets++;
        `CHK(drum_done, 1'b1)
        `CHK(drum_bad, bad)
        if (!bad) `CHK((n >= 4 * REV) && (n <= 6 * REV), 1'b1)
        if (!bad) `CHK(sets, 51)
        if (!bad) `CHK(pc_set_addr, jp)
    endtask
    task automatic t_drum;
        drum(8'h00, 12'h100, 8'd3, 12'h2BF, 1'b1);
        drum(8'hBD, 12'h100, 8'd200, 12'h2BF, 1'b1);
        for (int i = 0; i < 50; i++) wr(10'(10'h100 + i), RMD_FROM_ACC, 40'h5A00000000 | 40'(i), '0);
        drum(8'hBD, 12'h100, 8'd199, 12'h2BF, 1'b0);
        drum(8'hBC, 12'h200, 8'd199, 12'h123, 1'b0);
        rd(RMD_READ, RMD_TO_OPREG, 10'h200, 40'h5A00000000);
        rd(RMD_READ, RMD_TO_OPREG, 10'h231, 40'h5A00000031);
    endtask
    initial begin
        rst_b = 1'b0;
        drum_req = 1'b0;
        drum_order = '0;
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        t_rw();
        t_comp();
        t_gates();
        t_drum();
        give_verdict();
    end
endmodule
